// ==== csf_pkg.sv ====
/*
 * Shared constants and types for the processor status flags register.
 * Assumes a single instruction clock and a core that presents one
 * instruction's effects per clock cycle.
 */
package csf_pkg;

   localparam int DATA_W = 8;
   localparam int FILE_ADDR_W = 9;
   localparam int BANK_OFS_W = 7;

   // Offset of the register inside every bank.
   localparam logic [BANK_OFS_W-1:0] STATUS_OFS = 7'h03;

   // Field positions.
   localparam int BIT_IND_BANK = 7;
   localparam int BIT_DIR_BANK_HI = 6;
   localparam int BIT_DIR_BANK_LO = 5;
   localparam int BIT_WDT_EXP = 4;
   localparam int BIT_SLEEP_ENT = 3;
   localparam int BIT_Z = 2;
   localparam int BIT_NIB_C = 1;
   localparam int BIT_C = 0;
   localparam int NIB_W = 4;

   // Write masks and the value after power-on reset.
   localparam logic [DATA_W-1:0] BANK_MASK = 8'he0;
   localparam logic [DATA_W-1:0] ARITH_MASK = 8'h07;
   localparam logic [DATA_W-1:0] STATUS_RST = 8'h18;
   localparam logic [DATA_W-1:0] ZERO_BYTE = 8'h00;

   // Flag effect requested by the executing instruction.
   typedef enum logic [2:0] {
      ALU_NONE,
      ALU_ADD,
      ALU_SUB,
      ALU_LOGIC,
      ALU_RLF,
      ALU_RRF
   } csf_alu_op_t;

   // True for any of the four aliases of the register.
   function automatic logic is_status_addr(input logic [FILE_ADDR_W-1:0] addr);
      is_status_addr = (addr[BANK_OFS_W-1:0] == STATUS_OFS);
   endfunction

endpackage

// ==== csf_flag_alu.sv ====
/*
 * Flag generator: derives zero, nibble carry and carry from the operands.
 * Assumes operands are stable for the cycle in which the op is presented.
 */
`timescale 1ns/1ns
module csf_flag_alu (
   input wire csf_pkg::csf_alu_op_t op_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input wire logic carry_in_i,
   output logic z_o,
   output logic nc_o,
   output logic c_o,
   output logic aff_z_o,
   output logic aff_nc_o,
   output logic aff_c_o
);

   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] res;

   // Subtraction adds the two's complement, so carries come out as inverted borrows.
   always_comb begin
      sum = 9'h000;
      nib = 5'h00;
      res = a_i;
      c_o = 1'b0;
      aff_z_o = 1'b0;
      aff_nc_o = 1'b0;
      aff_c_o = 1'b0;
      case (op_i)
         csf_pkg::ALU_ADD: begin
            sum = {1'b0, a_i} + {1'b0, b_i};
            nib = {1'b0, a_i[3:0]} + {1'b0, b_i[3:0]};
            res = sum[7:0];
            c_o = sum[8];
            aff_z_o = 1'b1;
            aff_nc_o = 1'b1;
            aff_c_o = 1'b1;
         end
         csf_pkg::ALU_SUB: begin
            sum = {1'b0, a_i} + {1'b0, ~b_i} + 9'h001;
            nib = {1'b0, a_i[3:0]} + {1'b0, ~b_i[3:0]} + 5'h01;
            res = sum[7:0];
            c_o = sum[8];
            aff_z_o = 1'b1;
            aff_nc_o = 1'b1;
            aff_c_o = 1'b1;
         end
         csf_pkg::ALU_LOGIC: begin
            aff_z_o = 1'b1;
         end
         csf_pkg::ALU_RLF: begin
            c_o = a_i[7];
            aff_c_o = 1'b1;
         end
         csf_pkg::ALU_RRF: begin
            c_o = a_i[0];
            aff_c_o = 1'b1;
         end
         default: begin
            res = a_i;
         end
      endcase
      // Only rotate left uses the carry-in path; it only feeds the result.
      if (op_i == csf_pkg::ALU_RLF) begin
         res = {a_i[6:0], carry_in_i};
      end
      z_o = (res == csf_pkg::ZERO_BYTE);
      nc_o = nib[csf_pkg::NIB_W];
   end

endmodule

// ==== csf_bank_addr.sv ====
/*
 * Bank address composer for direct and indirect data-memory accesses.
 * Assumes the bank select bits come from the status register itself.
 */
`timescale 1ns/1ns
module csf_bank_addr (
   input wire logic indirect_bank_select_i,
   input wire logic [1:0] direct_bank_select_i,
   input wire logic [6:0] dir_offset_i,
   input wire logic [7:0] ind_pointer_i,
   output logic [8:0] dir_file_addr_o,
   output logic [8:0] ind_file_addr_o
);

   // Direct: bank bits above a 7-bit offset; indirect: one bit above the 8-bit pointer.
   always_comb begin
      dir_file_addr_o = {direct_bank_select_i, dir_offset_i};
      ind_file_addr_o = {indirect_bank_select_i, ind_pointer_i};
   end

endmodule

// ==== csf_status_reg.sv ====
/*
 * Processor status flags register with its bank address outputs.
 * Assumes the core presents at most one instruction per clock, with the
 * file write, the flag effect and the reset-cause events of that
 * instruction all in the same cycle, and that power-on drives rst_n_i.
 */
`timescale 1ns/1ns
module csf_status_reg (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic wr_en_i,
   input wire logic [8:0] wr_addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic clear_file_op_i,
   input wire logic [8:0] rd_addr_i,
   input wire csf_pkg::csf_alu_op_t alu_op_i,
   input wire logic [7:0] alu_a_i,
   input wire logic [7:0] alu_b_i,
   input wire logic watchdog_clear_op_i,
   input wire logic sleep_op_i,
   input wire logic wdt_timeout_i,
   input wire logic [6:0] dir_offset_i,
   input wire logic [7:0] ind_pointer_i,
   output logic [7:0] status_o,
   output logic [7:0] rd_data_o,
   output logic rd_hit_o,
   output logic [8:0] dir_file_addr_o,
   output logic [8:0] ind_file_addr_o
);

   typedef struct packed {
      logic [7:0] status;
      logic [7:0] rd_data;
      logic rd_hit;
      logic [8:0] dir_addr;
      logic [8:0] ind_addr;
   } csf_state_t;

   csf_state_t s_q;
   csf_state_t s_d;

   logic alu_z;
   logic alu_nc;
   logic alu_c;
   logic aff_z;
   logic aff_nc;
   logic aff_c;
   logic [8:0] dir_addr_c;
   logic [8:0] ind_addr_c;
   logic wr_hit;
   logic flags_busy;
   logic eff_z;
   logic [7:0] wr_val;
   logic [7:0] wr_mask;
   logic [7:0] nxt;

   csf_pkg::csf_alu_op_t eff_op;

   // A clear-file instruction writes zero and reports a zero result.
   always_comb begin
      eff_op = alu_op_i;
      if (clear_file_op_i) begin
         eff_op = csf_pkg::ALU_LOGIC;
      end
   end

   csf_flag_alu u_flag_alu (
      .op_i(eff_op),
      .a_i(clear_file_op_i ? csf_pkg::ZERO_BYTE : alu_a_i),
      .b_i(alu_b_i),
      .carry_in_i(s_q.status[csf_pkg::BIT_C]),
      .z_o(alu_z),
      .nc_o(alu_nc),
      .c_o(alu_c),
      .aff_z_o(aff_z),
      .aff_nc_o(aff_nc),
      .aff_c_o(aff_c)
   );

   csf_bank_addr u_bank_addr (
      .indirect_bank_select_i(s_q.status[csf_pkg::BIT_IND_BANK]),
      .direct_bank_select_i(s_q.status[csf_pkg::BIT_DIR_BANK_HI:csf_pkg::BIT_DIR_BANK_LO]),
      .dir_offset_i(dir_offset_i),
      .ind_pointer_i(ind_pointer_i),
      .dir_file_addr_o(dir_addr_c),
      .ind_file_addr_o(ind_addr_c)
   );

   // Every bank alias reaches the one register; upper address bits are ignored.
   always_comb begin
      wr_hit = wr_en_i && csf_pkg::is_status_addr(wr_addr_i);
      flags_busy = aff_z || aff_nc || aff_c;
      eff_z = alu_z;
      wr_val = clear_file_op_i ? csf_pkg::ZERO_BYTE : wr_data_i;
   end

   // Write mask: the reset-cause flags are never writable, and the arithmetic
   // flags drop out whenever the same instruction produces any of them.
   always_comb begin
      wr_mask = csf_pkg::BANK_MASK;
      if (!flags_busy) begin
         wr_mask = csf_pkg::BANK_MASK | csf_pkg::ARITH_MASK;
      end
   end

   // Next state. Order matters: write first, then flag results override the
   // masked bits, then hardware events decide the reset-cause flags.
   always_comb begin
      s_d = s_q;
      nxt = s_q.status;
      if (wr_hit) begin
         nxt = (nxt & ~wr_mask) | (wr_val & wr_mask);
      end
      if (aff_z) begin
         nxt[csf_pkg::BIT_Z] = eff_z;
      end
      if (aff_nc) begin
         nxt[csf_pkg::BIT_NIB_C] = alu_nc;
      end
      if (aff_c) begin
         nxt[csf_pkg::BIT_C] = alu_c;
      end
      // Watchdog clear restores both flags to their power-up value.
      if (watchdog_clear_op_i) begin
         nxt[csf_pkg::BIT_WDT_EXP] = 1'b1;
         nxt[csf_pkg::BIT_SLEEP_ENT] = 1'b1;
      end
      // Sleep marks power-down and sets the time-out flag.
      if (sleep_op_i) begin
         nxt[csf_pkg::BIT_WDT_EXP] = 1'b1;
         nxt[csf_pkg::BIT_SLEEP_ENT] = 1'b0;
      end
      // A timeout is the event software must never miss, so it wins last.
      if (wdt_timeout_i) begin
         nxt[csf_pkg::BIT_WDT_EXP] = 1'b0;
      end
      s_d.status = nxt;
      // Reads return the value held before this cycle's update.
      s_d.rd_hit = csf_pkg::is_status_addr(rd_addr_i);
      s_d.rd_data = csf_pkg::is_status_addr(rd_addr_i) ? s_q.status : csf_pkg::ZERO_BYTE;
      s_d.dir_addr = dir_addr_c;
      s_d.ind_addr = ind_addr_c;
   end

   // State register. Power-on leaves both reset-cause flags set and banks at zero.
   always_ff @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         s_q.status <= csf_pkg::STATUS_RST;
         s_q.rd_data <= csf_pkg::ZERO_BYTE;
         s_q.rd_hit <= 1'b0;
         s_q.dir_addr <= 9'h000;
         s_q.ind_addr <= 9'h000;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state register.
   assign status_o = s_q.status;
   assign rd_data_o = s_q.rd_data;
   assign rd_hit_o = s_q.rd_hit;
   assign dir_file_addr_o = s_q.dir_addr;
   assign ind_file_addr_o = s_q.ind_addr;

   // Helper sums that let the checks below recompute carries independently.
   logic [8:0] chk_add_sum;
   logic [4:0] chk_add_nib;
   logic chk_no_event;

   always_comb begin
      chk_add_sum = {1'b0, alu_a_i} + {1'b0, alu_b_i};
      chk_add_nib = {1'b0, alu_a_i[3:0]} + {1'b0, alu_b_i[3:0]};
      chk_no_event = !watchdog_clear_op_i && !sleep_op_i && !wdt_timeout_i;
   end

   // The edge that leaves reset still loads reset values, so checks that could
   // fire in any cycle also sample rst_n_i in their antecedent.
   default clocking cb @(posedge clk_sys_i);
   endclocking

   default disable iff (!rst_n_i);

   // Instruction writes leave the reset-cause flags alone.
   a_cause_flags_locked: assert property (
      (wr_hit && chk_no_event)
      |=> (status_o[4:3] == $past(status_o[4:3])))
      else $error("Reset-cause flags changed by an instruction write.");

   // A write during an add does not reach the carry flag.
   a_arith_write_blocked: assert property (
      (wr_hit && !clear_file_op_i && alu_op_i == csf_pkg::ALU_ADD)
      |=> (status_o[0] == $past(chk_add_sum[8])))
      else $error("Explicit write reached the carry flag during an add.");

   // Clear-file yields 000uu1uu.
   a_clear_file_pattern: assert property (
      (wr_hit && clear_file_op_i && chk_no_event)
      |=> (status_o == {3'b000, $past(status_o[4:3]), 1'b1, $past(status_o[1:0])}))
      else $error("Clear-file did not give the expected pattern.");

   // Subtraction carry is high exactly when no borrow occurred.
   a_sub_borrow: assert property (
      (alu_op_i == csf_pkg::ALU_SUB && !clear_file_op_i)
      |=> (status_o[0] == ($past(alu_a_i) >= $past(alu_b_i))))
      else $error("Subtraction carry is not the inverted borrow.");

   // Subtraction nibble carry is high exactly when the low nibble did not borrow.
   a_sub_nibble_borrow: assert property (
      (alu_op_i == csf_pkg::ALU_SUB && !clear_file_op_i)
      |=> (status_o[1] == ($past(alu_a_i[3:0]) >= $past(alu_b_i[3:0]))))
      else $error("Subtraction nibble carry is not the inverted borrow.");

   // Add carries out of bit 7 and out of bit 3.
   a_add_carries: assert property (
      (alu_op_i == csf_pkg::ALU_ADD && !clear_file_op_i)
      |=> (status_o[0] == $past(chk_add_sum[8]))
          && (status_o[1] == $past(chk_add_nib[4])))
      else $error("Add carries do not match the operands.");

   // Zero flag tracks a logic result.
   a_zero_logic: assert property (
      (alu_op_i == csf_pkg::ALU_LOGIC && !clear_file_op_i)
      |=> (status_o[2] == ($past(alu_a_i) == 8'h00)))
      else $error("Zero flag does not follow the logic result.");

   // A watchdog timeout clears the expiry flag.
   a_timeout_clears: assert property (
      wdt_timeout_i |=> !status_o[4])
      else $error("Watchdog timeout did not clear the expiry flag.");

   // Sleep sets the expiry flag and clears the sleep-entered flag.
   a_sleep_flags: assert property (
      (sleep_op_i && !wdt_timeout_i) |=> (status_o[4] && !status_o[3]))
      else $error("Sleep did not leave the expected reset-cause flags.");

   // Watchdog clear alone sets both reset-cause flags.
   a_wdt_clear_flags: assert property (
      (watchdog_clear_op_i && !sleep_op_i && !wdt_timeout_i)
      |=> (status_o[4:3] == 2'b11))
      else $error("Watchdog clear did not set both reset-cause flags.");

   // A flag-neutral write at any alias stores every writable bit.
   a_plain_write: assert property (
      (wr_hit && alu_op_i == csf_pkg::ALU_NONE && !clear_file_op_i && chk_no_event)
      |=> (status_o[7:5] == $past(wr_data_i[7:5]))
          && (status_o[2:0] == $past(wr_data_i[2:0])))
      else $error("Flag-neutral write was not stored.");

   // Direct address uses the bank selects held one cycle earlier.
   a_direct_bank: assert property (
      rst_n_i |=> (dir_file_addr_o == {$past(status_o[6:5]), $past(dir_offset_i)}))
      else $error("Direct address does not carry the bank select.");

   // Indirect address uses the indirect bank bit held one cycle earlier.
   a_indirect_bank: assert property (
      rst_n_i |=> (ind_file_addr_o == {$past(status_o[7]), $past(ind_pointer_i)}))
      else $error("Indirect address does not carry the bank bit.");

   // Reads at any alias return the register, two cycles of hold not required.
   a_read_alias: assert property (
      (rst_n_i && rd_addr_i[6:0] == 7'h03) |=> (rd_hit_o && rd_data_o == $past(status_o)))
      else $error("Read at a status alias did not return the register.");

   // Reads elsewhere report a miss and return zero.
   a_read_miss: assert property (
      (rst_n_i && rd_addr_i[6:0] != 7'h03)
      |=> (!rd_hit_o && rd_data_o == 8'h00))
      else $error("Read away from the register did not report a miss.");

   // Rotate left loads carry from the top operand bit and leaves zero alone.
   a_rotate_left_carry: assert property (
      (alu_op_i == csf_pkg::ALU_RLF && !clear_file_op_i)
      |=> (status_o[0] == $past(alu_a_i[7]))
          && (status_o[2] == $past(status_o[2])))
      else $error("Rotate left did not load carry from the top bit.");

   // Rotate right loads carry from the bottom operand bit and leaves zero alone.
   a_rotate_right_carry: assert property (
      (alu_op_i == csf_pkg::ALU_RRF && !clear_file_op_i)
      |=> (status_o[0] == $past(alu_a_i[0]))
          && (status_o[2] == $past(status_o[2])))
      else $error("Rotate right did not load carry from the bottom bit.");

   // Bank selects still take the written value while the flags are blocked.
   a_bank_write_kept: assert property (
      (wr_hit && flags_busy && !clear_file_op_i)
      |=> (status_o[7:5] == $past(wr_data_i[7:5])))
      else $error("Bank selects were not written during a flag operation.");

   // A logic op owns the zero flag; the write must not reach the carries.
   a_logic_write_blocked: assert property (
      (wr_hit && alu_op_i == csf_pkg::ALU_LOGIC && !clear_file_op_i)
      |=> (status_o[1:0] == $past(status_o[1:0])))
      else $error("Explicit write reached the carries during a logic op.");

   // With no write, no flag effect and no event the register holds.
   a_status_holds: assert property (
      (rst_n_i && !wr_hit && alu_op_i == csf_pkg::ALU_NONE
       && !clear_file_op_i && chk_no_event)
      |=> (status_o == $past(status_o)))
      else $error("Register changed with nothing acting on it.");

   // Timeout and sleep together leave both reset-cause flags clear.
   a_timeout_beats_sleep: assert property (
      (sleep_op_i && wdt_timeout_i) |=> (status_o[4:3] == 2'b00))
      else $error("Timeout did not win over sleep.");

endmodule

// ==== csf_core_model.sv ====
/*
 * Core-side model: turns one instruction code per cycle into the control
 * pins of the status register. Assumes codes change just after clock edges.
 */
`timescale 1ns/1ns
module csf_core_model (
   input wire logic [2:0] kind_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   output logic wr_en_o,
   output logic clr_o,
   output csf_pkg::csf_alu_op_t op_o,
   output logic [7:0] data_o,
   output logic wdc_o,
   output logic slp_o
);
   // Codes: 1 move, 2 clear, 3 add, 4 sub, 5 logic, 6 watchdog clear, 7 sleep.
   // Code 0 is idle, or a rotate into the working register when b_i[1:0] is 1 or 2.
   // Move never carries a flag effect, so it is the safe way to load the register.
   always_comb begin
      wr_en_o = (kind_i != 3'h0) && (kind_i < 3'h6);
      clr_o = (kind_i == 3'h2);
      wdc_o = (kind_i == 3'h6);
      slp_o = (kind_i == 3'h7);
      op_o = csf_pkg::ALU_NONE;
      data_o = b_i;
      case (kind_i)
         3'h0: begin
            if (b_i[1:0] == 2'h1) begin
               op_o = csf_pkg::ALU_RLF;
            end
            if (b_i[1:0] == 2'h2) begin
               op_o = csf_pkg::ALU_RRF;
            end
         end
         3'h2: data_o = 8'h00;
         3'h3: begin
            op_o = csf_pkg::ALU_ADD;
            data_o = a_i + b_i;
         end
         3'h4: begin
            op_o = csf_pkg::ALU_SUB;
            data_o = a_i - b_i;
         end
         3'h5: begin
            op_o = csf_pkg::ALU_LOGIC;
            data_o = a_i;
         end
         default: ;
      endcase
   end
endmodule

// ==== testbench.sv ====
/*
 * Self-checking bench for the status flags register, driven through the
 * core model. Assumes every output is registered one cycle after its cause.
 */
`timescale 1ns/1ns
module testbench;
   logic clk_sys_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [2:0] kind = 3'h0;
   logic [7:0] op_a = 8'h00;
   logic [7:0] op_b = 8'h00;
   logic [8:0] addr = 9'h000;
   logic [8:0] rd_addr = 9'h000;
   logic tmo = 1'b0;
   logic [6:0] off = 7'h00;
   logic [7:0] ptr = 8'h00;
   logic wr_en, clr, wdc, slp, rd_hit;
   logic [7:0] data, status, rd_data;
   logic [8:0] dir, ind, ad;
   logic [2:0] k;
   csf_pkg::csf_alu_op_t op;
   logic [7:0] e_st = 8'h18;
   logic [7:0] e_rd = 8'h00;
   logic e_hit = 1'b0;
   logic [8:0] e_dir = 9'h000;
   logic [8:0] e_ind = 9'h000;
   int n_errors = 0;
   int samples_checked = 0;

   // Free-running instruction clock, 40 ns period.
   initial begin
      forever #20 clk_sys_i = ~clk_sys_i;
   end

   csf_core_model partner (.kind_i(kind), .a_i(op_a), .b_i(op_b), .wr_en_o(wr_en),
      .clr_o(clr), .op_o(op), .data_o(data), .wdc_o(wdc), .slp_o(slp));

   csf_status_reg uut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wr_en_i(wr_en),
      .wr_addr_i(addr), .wr_data_i(data), .clear_file_op_i(clr), .rd_addr_i(rd_addr),
      .alu_op_i(op), .alu_a_i(op_a), .alu_b_i(op_b), .watchdog_clear_op_i(wdc),
      .sleep_op_i(slp), .wdt_timeout_i(tmo), .dir_offset_i(off), .ind_pointer_i(ptr),
      .status_o(status), .rd_data_o(rd_data), .rd_hit_o(rd_hit),
      .dir_file_addr_o(dir), .ind_file_addr_o(ind));

   // Next register value for one instruction; timeout is applied last so it wins.
   function automatic logic [7:0] nxt(input logic [7:0] s, input logic [2:0] c,
      input logic [7:0] a, input logic [7:0] b, input logic [8:0] d, input logic t);
      logic [8:0] r;
      logic hit;
      hit = (d[6:0] == 7'h03);
      r = (c == 3'h3) ? {1'b0, a} + {1'b0, b} : {1'b0, a} - {1'b0, b};
      case (c)
         3'h0: begin
            if (b[1:0] == 2'h1) s[0] = a[7];
            if (b[1:0] == 2'h2) s[0] = a[0];
         end
         3'h1: if (hit) s = (s & 8'h18) | (b & 8'he7);
         3'h2: s = hit ? ((s & 8'h1b) | 8'h04) : (s | 8'h04);
         3'h3, 3'h4: begin
            if (hit) s[7:5] = r[7:5];
            s[2] = (r[7:0] == 8'h00);
            s[1] = (c == 3'h3) ? (a[3:0] + b[3:0] > 5'h0f) : (a[3:0] >= b[3:0]);
            s[0] = (c == 3'h3) ? r[8] : (a >= b);
         end
         3'h5: begin
            if (hit) s[7:5] = a[7:5];
            s[2] = (a == 8'h00);
         end
         3'h6: s[4:3] = 2'b11;
         3'h7: s[4:3] = 2'b10;
         default: ;
      endcase
      if (t) s[4] = 1'b0;
      return s;
   endfunction

   task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_errors++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // One instruction per edge: predict from what the edge samples, then drive the next.
   task automatic step(input logic r, input logic [2:0] c, input logic [7:0] a,
      input logic [7:0] b, input logic [8:0] d, input logic t);
      @(posedge clk_sys_i);
      e_hit = rst_n_i && (rd_addr[6:0] == 7'h03);
      e_rd = e_hit ? e_st : 8'h00;
      e_dir = rst_n_i ? {e_st[6:5], off} : 9'h000;
      e_ind = rst_n_i ? {e_st[7], ptr} : 9'h000;
      e_st = rst_n_i ? nxt(e_st, kind, op_a, op_b, addr, tmo) : 8'h18;
      rst_n_i <= r;
      kind <= c;
      op_a <= a;
      op_b <= b;
      addr <= d;
      tmo <= t;
      rd_addr <= ($urandom_range(1) == 1) ? {d[8:7], 7'h03} : d;
      off <= 7'($urandom);
      ptr <= 8'($urandom);
      #1;
      chk(9'(status), 9'(e_st));
      chk(9'(rd_data), 9'(e_rd));
      chk(9'(rd_hit), 9'(e_hit));
      chk(dir, e_dir);
      chk(ind, e_ind);
   endtask

   task automatic tally_and_finish;
      $display("Checks %0d, mismatches %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // Corner cases first, then random traffic with a reset in between.
   initial begin
      void'($urandom(32'hecfbe134));
      repeat (20) step(1'b0, 3'h0, 8'h00, 8'h00, 9'h000, 1'b0);
      step(1'b1, 3'h1, 8'h00, 8'hff, 9'h083, 1'b0);
      step(1'b1, 3'h2, 8'h00, 8'h00, 9'h103, 1'b0);
      step(1'b1, 3'h1, 8'h00, 8'ha5, 9'h183, 1'b0);
      step(1'b1, 3'h4, 8'h05, 8'h06, 9'h003, 1'b0);
      step(1'b1, 3'h4, 8'h33, 8'h33, 9'h183, 1'b0);
      step(1'b1, 3'h3, 8'hff, 8'h01, 9'h010, 1'b0);
      step(1'b1, 3'h3, 8'h0f, 8'h01, 9'h003, 1'b0);
      step(1'b1, 3'h5, 8'h00, 8'h00, 9'h050, 1'b0);
      step(1'b1, 3'h0, 8'h80, 8'h01, 9'h003, 1'b0);
      step(1'b1, 3'h0, 8'h02, 8'h02, 9'h003, 1'b0);
      step(1'b1, 3'h7, 8'h00, 8'h00, 9'h000, 1'b1);
      step(1'b1, 3'h6, 8'h00, 8'h00, 9'h000, 1'b0);
      step(1'b1, 3'h7, 8'h00, 8'h00, 9'h000, 1'b0);
      step(1'b1, 3'h0, 8'h00, 8'h00, 9'h000, 1'b1);
      repeat (2) begin
         repeat (300) begin
            k = 3'($urandom);
            ad = 9'($urandom);
            if (k == 3'h2 || $urandom_range(1) == 1) ad[6:0] = 7'h03;
            step(1'b1, k, 8'($urandom), 8'($urandom), ad, $urandom_range(15) == 0);
         end
         repeat (3) step(1'b0, 3'h0, 8'h00, 8'h00, 9'h000, 1'b0);
      end
      step(1'b1, 3'h0, 8'h00, 8'h00, 9'h000, 1'b0);
      tally_and_finish();
   end

   // The run needs about 640 cycles; a hang is cut off well past that.
   initial begin
      repeat (3000) @(posedge clk_sys_i);
      n_errors++;
      tally_and_finish();
   end
endmodule
